// *** dv/rtc_apb_master.sv ***
module rtc_apb_master (
	// bus
	input wire logic        pclk,
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic [13:0]     paddr,
	output logic [31:0]     pwdata,
	output logic [3:0]      pstrb,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 14'h0000;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
	end

	// one register per word, byte address is four times the index
	task automatic xfer(input logic wr, input logic [11:0] idx,
			input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released data no longer shows the last value
		pwdata <= ~wd;
	endtask
endmodule

// *** dv/rtc_regulator_ctl_assertions.sv ***
module rtc_regulator_ctl_assertions
	import rtc_pkg::*;
(
	// system and bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// power and events
	input wire logic        regulator_enable_pin,
	input wire logic        mcu_stop,
	input wire logic        temp_sense_on,
	input wire logic        adc_internal_sel,
	input wire logic        adc_bandgap_sel,
	input wire logic        temp_irq
);
	logic take;
	logic abort_reg;

	assign take = psel && penable && !pready;

	// shadow of the abort enable, since the checker cannot see registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_reg <= 1'b1;
		end else if (take && pwrite && pstrb[0] && paddr[13:2] == IDX_SYS_CTL) begin
			abort_reg <= pwdata[SYS_ABORT];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	rdy_pulse_a: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	rdy_answer_a: assert property (take |=> pready)
		else $error("pready missing after access");
	rsvd_abort_a: assert property (
		take && paddr[13:2] == IDX_RESERVED && abort_reg |=> pslverr && prdata == 32'h0)
		else $error("reserved access not aborted");
	zero_bits_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("unused read bits not zero");
	bandgap_route_a: assert property (adc_bandgap_sel |-> adc_internal_sel)
		else $error("bandgap routed without access");
	sense_off_a: assert property (
		(!regulator_enable_pin || mcu_stop) [*5] |-> !temp_sense_on)
		else $error("sensor on outside full mode");
	flag_sticky_a: assert property (temp_irq && !(psel && pwrite) |=> temp_irq)
		else $error("temperature request dropped without write");
	status_off_a: assert property (
		pready && !pwrite && paddr[13:2] == IDX_TEMP_CTL && !regulator_enable_pin
		&& !$past(regulator_enable_pin, 6) |-> !prdata[TC_STAT])
		else $error("status set in shutdown");

	cover property (take && paddr[13:2] == IDX_RESERVED && abort_reg);
	cover property ($rose(temp_irq));
	cover property ($rose(adc_bandgap_sel));
endmodule

bind rtc_regulator_ctl rtc_regulator_ctl_assertions i_chk (.*);

// *** dv/rtc_regulator_ctl_tb_top.sv ***
module rtc_regulator_ctl_tb_top
	import rtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic        wr;
		logic [11:0] idx;
		logic [7:0]  wd;
		logic [7:0]  rd;
		logic        err;
		logic        ai;
		logic        bg;
	} rtc_row_type;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        regulator_enable_pin, mcu_stop, err_v;
	logic        temp_above_assert, temp_below_deassert;
	logic        temp_sense_on, adc_internal_sel, adc_bandgap_sel, temp_irq, irq;
	logic        clk_en, wake_tick, lv_below_assert, lv_above_deassert;
	logic        lv_irq, periodic_wakeup_output_pin, wk_a;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	logic [3:0]  pstrb;
	int          fail_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	rtc_row_type rows [15];

	rtc_apb_master i_mst (.*);
	rtc_regulator_ctl i_dut (.*);

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fail_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chkw(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chkb(input string name, input logic exp, input logic got);
		chkw(name, {31'h0, exp}, {31'h0, got});
	endtask

	task automatic rw(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
		i_mst.xfer(wr, idx, {24'h000000, wd}, rd_v, err_v);
	endtask

	task automatic settle();
		repeat (8) @(posedge pclk);
		@(negedge pclk);
	endtask

	initial begin
		presetn = 1'b0;
		regulator_enable_pin = 1'b1;
		mcu_stop = 1'b0;
		temp_above_assert = 1'b0;
		temp_below_deassert = 1'b0;
		clk_en = 1'b1;
		wake_tick = 1'b0;
		lv_below_assert = 1'b0;
		lv_above_deassert = 1'b0;
		rows = '{
			'{1'b1, IDX_TEMP_CTL, 8'hFF, 8'h00, 1'b0, 1'b1, 1'b1},
			'{1'b0, IDX_TEMP_CTL, 8'h00, 8'h3A, 1'b0, 1'b1, 1'b1},
			'{1'b1, IDX_TEMP_CTL, 8'h10, 8'h00, 1'b0, 1'b1, 1'b0},
			'{1'b1, IDX_TEMP_CTL, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0},
			'{1'b0, IDX_RESERVED, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0},
			'{1'b1, IDX_SYS_CTL,  8'h00, 8'h00, 1'b0, 1'b0, 1'b0},
			'{1'b0, IDX_RESERVED, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0},
			'{1'b1, IDX_SYS_CTL,  8'h01, 8'h00, 1'b0, 1'b0, 1'b0},
			'{1'b1, IDX_RESERVED, 8'h55, 8'h00, 1'b1, 1'b0, 1'b0},
			'{1'b0, 12'h2FB,      8'h00, 8'h00, 1'b1, 1'b0, 1'b0},
			'{1'b1, IDX_SYS_CTL,  8'h05, 8'h00, 1'b0, 1'b0, 1'b0},
			'{1'b1, IDX_TEMP_CTL, 8'hC0, 8'h00, 1'b0, 1'b0, 1'b0},
			'{1'b0, IDX_TEMP_CTL, 8'h00, 8'hC0, 1'b0, 1'b0, 1'b0},
			'{1'b1, IDX_TEMP_CTL, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0},
			'{1'b1, IDX_SYS_CTL,  8'h01, 8'h00, 1'b0, 1'b0, 1'b0}};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rw(1'b0, IDX_TEMP_CTL, 8'h00);
		chkw("temp reset", {24'h0, TC_RESET}, rd_v);
		chkb("access reset", 1'b1, adc_internal_sel);
		foreach (rows[i]) begin
			rw(rows[i].wr, rows[i].idx, rows[i].wd);
			@(negedge pclk);
			chkb("slverr", rows[i].err, err_v);
			if (!rows[i].wr) chkw("rdata", {24'h0, rows[i].rd}, rd_v);
			chkb("adc internal", rows[i].ai, adc_internal_sel);
			chkb("adc bandgap", rows[i].bg, adc_bandgap_sel);
		end
		rw(1'b1, IDX_TEMP_CTL, 8'h0A);
		temp_above_assert <= 1'b1;
		settle();
		chkb("sense on", 1'b1, temp_sense_on);
		chkb("temp irq", 1'b1, temp_irq);
		chkb("masked irq", 1'b0, irq);
		rw(1'b0, IDX_TEMP_CTL, 8'h00);
		chkw("temp hot", 32'h0F, rd_v);
		rw(1'b1, IDX_IRQ_MASK, 8'h01);
		@(negedge pclk);
		chkb("unmasked irq", 1'b1, irq);
		rw(1'b1, IDX_TEMP_CTL, 8'h0A);
		settle();
		chkb("zero kept flag", 1'b1, temp_irq);
		rw(1'b1, IDX_TEMP_CTL, 8'h0B);
		settle();
		chkb("flag cleared", 1'b0, temp_irq);
		chkb("irq cleared", 1'b0, irq);
		@(posedge pclk);
		temp_above_assert <= 1'b0;
		temp_below_deassert <= 1'b1;
		settle();
		chkb("falling change", 1'b1, temp_irq);
		rw(1'b1, IDX_LV_CTL, 8'h02);
		lv_below_assert <= 1'b1;
		settle();
		chkb("lv irq", 1'b1, lv_irq);
		rw(1'b1, IDX_LV_CTL, 8'h03);
		rw(1'b0, IDX_LV_CTL, 8'h00);
		chkw("lv cleared", 32'h06, rd_v);
		mcu_stop <= 1'b1;
		settle();
		rw(1'b0, IDX_TEMP_CTL, 8'h00);
		chkw("reduced power", 32'h0B, rd_v);
		rw(1'b1, IDX_TEMP_CTL, 8'h08);
		settle();
		chkb("ie off", 1'b0, temp_irq);
		rw(1'b0, IDX_TEMP_CTL, 8'h00);
		chkw("flag kept", 32'h09, rd_v);
		// timer reloads at two, so the exposed clock flips every third tick
		rw(1'b1, IDX_WK_RATE_LO, 8'h02);
		wake_tick <= 1'b1;
		rw(1'b1, IDX_SYS_CTL, 8'h03);
		rw(1'b1, IDX_WK_CTL, 8'h1C);
		settle();
		wk_a = periodic_wakeup_output_pin;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chkb("wakeup toggle", ~wk_a, periodic_wakeup_output_pin);
		@(posedge pclk);
		clk_en <= 1'b0;
		@(negedge pclk);
		wk_a = periodic_wakeup_output_pin;
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		chkb("frozen pin", wk_a, periodic_wakeup_output_pin);
		@(posedge pclk);
		clk_en <= 1'b1;
		rw(1'b0, IDX_IRQ_STAT, 8'h00);
		chkb("wakeup flag", 1'b1, rd_v[IRQ_WK]);
		rw(1'b1, IDX_WK_CTL, 8'h01);
		@(negedge pclk);
		chkb("wakeup pin off", 1'b0, periodic_wakeup_output_pin);
		rw(1'b0, IDX_WK_CTL, 8'h00);
		chkw("wakeup cleared", 32'h00, rd_v);
		// shutdown is only changed across a reset, never while running
		presetn <= 1'b0;
		regulator_enable_pin <= 1'b0;
		mcu_stop <= 1'b0;
		temp_above_assert <= 1'b1;
		temp_below_deassert <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rw(1'b1, IDX_TEMP_CTL, 8'h18);
		settle();
		chkb("shutdown sense", 1'b0, temp_sense_on);
		rw(1'b0, IDX_TEMP_CTL, 8'h00);
		chkw("shutdown status", 32'h18, rd_v);
		conclude();
	end
endmodule

// *** include/rtc_pkg.sv ***
package rtc_pkg;

	// ---------------------------------------------------------------
	// register map (printed offsets are not multiples of four: index)
	// ---------------------------------------------------------------
	localparam logic [11:0] IDX_TEMP_CTL   = 12'h2F0;
	localparam logic [11:0] IDX_LV_CTL     = 12'h2F1;
	localparam logic [11:0] IDX_WK_CTL     = 12'h2F2;
	localparam logic [11:0] IDX_WK_TRIM    = 12'h2F3;
	localparam logic [11:0] IDX_WK_RATE_HI = 12'h2F4;
	localparam logic [11:0] IDX_WK_RATE_LO = 12'h2F5;
	localparam logic [11:0] IDX_RESERVED   = 12'h2F6;
	localparam logic [11:0] IDX_TEMP_TRIM  = 12'h2F7;
	localparam logic [11:0] IDX_IRQ_STAT   = 12'h2F8;
	localparam logic [11:0] IDX_IRQ_MASK   = 12'h2F9;
	localparam logic [11:0] IDX_SYS_CTL    = 12'h2FA;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int TC_TEST_HI = 7;
	localparam int TC_TEST_LO = 6;
	localparam int TC_VOLTAGE_SOURCE_SELECT    = 5;
	localparam int TC_VAE     = 4;
	localparam int TC_EN      = 3;
	localparam int TC_STAT    = 2;
	localparam int TC_IE      = 1;
	localparam int TC_FLAG    = 0;
	localparam int LV_STAT    = 2;
	localparam int LV_IE      = 1;
	localparam int LV_FLAG    = 0;
	localparam int WK_CLK     = 7;
	localparam int WK_ES      = 4;
	localparam int WK_EA      = 3;
	localparam int WK_FE      = 2;
	localparam int WK_IE      = 1;
	localparam int WK_FLAG    = 0;
	localparam int IRQ_TEMP   = 0;
	localparam int IRQ_LV     = 1;
	localparam int IRQ_WK     = 2;
	localparam int SYS_ABORT  = 0;
	localparam int SYS_PINEN  = 1;
	localparam int SYS_TEST   = 2;

	// writable masks and reset values
	localparam logic [7:0] TC_WMASK     = 8'h3A;
	localparam logic [7:0] WK_WMASK     = 8'h9E;
	localparam logic [7:0] WK_TRIM_MASK = 8'hFC;
	localparam logic [7:0] TT_MASK      = 8'h8F;
	localparam logic [7:0] TC_RESET     = 8'h10;
	localparam logic [7:0] ZERO8        = 8'h00;
	localparam logic [2:0] IRQ_BITS     = 3'h7;
	// abort of reserved accesses is on out of reset
	localparam logic [2:0] SYS_RESET    = 3'h1;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		RTC_SHUTDOWN = 2'b00,
		RTC_FULL     = 2'b01,
		RTC_REDUCED  = 2'b10
	} rtc_mode_type;

	typedef struct packed {
		logic       voltage_source_select;
		logic       voltage_access_enable;
		logic       en;
		logic       ie;
		logic [1:0] test;
	} rtc_temp_cfg_type;

	typedef struct packed {
		logic        clk_sel;
		logic        ext_sel;
		logic        ext_acc;
		logic        feat_en;
		logic        ie;
		logic [7:0]  trim;
		logic [15:0] rate;
	} rtc_wake_cfg_type;

	typedef struct packed {
		logic [2:0]   sync_en;
		logic [2:0]   sync_temp;
		logic [2:0]   sync_lv;
		logic         temp_stat;
		logic         lv_stat;
		logic         lv_ie;
		logic [2:0]   flags;
		logic [2:0]   mask;
		logic [2:0]   sys;
		rtc_temp_cfg_type tc;
		rtc_wake_cfg_type wk;
		logic [7:0]   temp_trim;
		logic [15:0]  wk_cnt;
		logic         wk_phase;
		logic         wk_pulse;
		rtc_mode_type mode;
		logic         pready;
		logic         pslverr;
		logic [31:0]  prdata;
		logic         irq;
		logic         irq_temp;
		logic         irq_lv;
		logic         adc_int;
		logic         adc_bg;
		logic         sense_on;
		logic         wk_pin;
	} rtc_state_type;

endpackage

// *** src/rtc_regulator_ctl.sv ***
// Functional notes
// - shutdown while enable pin low, else run
// - abort accesses to reserved slot when enabled
// - test bits writable only in test mode
// - select bit picks bandgap or temperature voltage
// - access bit connects internal voltage to converter
// - sense enable bit switches sensor on in full mode
// - status read-only, high only in full mode
// - change flag set on any status change
// - flag cleared only by writing one
// - interrupt while flag set and enabled
// - reduced power entry keeps change flag
// - wakeup pin shows selected waveform when exposed
// - low-voltage flag same as temperature flag
// - wakeup flag clear beats timeout set
module rtc_regulator_ctl
	import rtc_pkg::*;
#(
	parameter int RATE_W = 16
) (
	// system
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [13:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// power and analog monitors
	input  wire logic        regulator_enable_pin,
	input  wire logic        mcu_stop,
	input  wire logic        temp_above_assert,
	input  wire logic        temp_below_deassert,
	input  wire logic        lv_below_assert,
	input  wire logic        lv_above_deassert,
	// wakeup timer tick (autonomous oscillator or bus clock)
	input  wire logic        wake_tick,
	// analog steering and events
	output logic             temp_sense_on,
	output logic             adc_internal_sel,
	output logic             adc_bandgap_sel,
	output logic             periodic_wakeup_output_pin,
	output logic             temp_irq,
	output logic             lv_irq,
	output logic             irq
);

	if (RATE_W != 16) begin : g_rate_chk
		$error("rate register is two bytes wide");
	end

	rtc_state_type s_reg;
	rtc_state_type s_next;

	// ---------------------------------------------------------------
	// register index decode
	// ---------------------------------------------------------------
	function automatic logic [11:0] reg_index(input logic [13:0] a);
		reg_index = a[13:2];
	endfunction

	function automatic logic mapped(input logic [11:0] i);
		mapped = (i >= IDX_TEMP_CTL) && (i <= IDX_SYS_CTL);
	endfunction

	logic        acc;
	logic        wr;
	logic [11:0] idx;
	logic [7:0]  wd;
	logic        full_mode;
	logic        temp_in;
	logic        lv_in;
	logic        wk_timeout;
	logic [2:0]  set_ev;
	logic [2:0]  clr_ev;
	logic [7:0]  rd;
	logic        bad;

	always_comb begin
		s_next = s_reg;
		acc = psel && penable && !s_reg.pready;
		wr = acc && pwrite && pstrb[0];
		idx = reg_index(paddr);
		wd = pwdata[7:0];
		rd = ZERO8;
		bad = !mapped(idx) || (idx == IDX_RESERVED && s_reg.sys[SYS_ABORT]);

		// -----------------------------------------------------------
		// operating mode
		// -----------------------------------------------------------
		// pin changes after power-up are unsupported, so the mode
		// simply follows the synchronised pin level
		s_next.sync_temp = {s_reg.sync_temp[1:0], temp_above_assert};
		s_next.sync_lv = {s_reg.sync_lv[1:0], lv_below_assert};
		// the enable pin is asynchronous: a level counts only once the
		// two later stages agree, so a slow edge cannot flicker the mode
		s_next.sync_en = {s_reg.sync_en[1:0], regulator_enable_pin};
		if (s_reg.sync_en[2] != s_reg.sync_en[1]) begin
			s_next.mode = s_reg.mode;
		end else if (!s_reg.sync_en[2]) begin
			s_next.mode = RTC_SHUTDOWN;
		end else if (mcu_stop) begin
			s_next.mode = RTC_REDUCED;
		end else begin
			s_next.mode = RTC_FULL;
		end
		full_mode = (s_reg.mode == RTC_FULL);

		// -----------------------------------------------------------
		// detectors with hysteresis
		// -----------------------------------------------------------
		temp_in = s_reg.sync_temp[2] & s_reg.sync_temp[1];
		lv_in = s_reg.sync_lv[2] & s_reg.sync_lv[1];
		if (!full_mode || !s_reg.tc.en) begin
			s_next.temp_stat = 1'b0;
		end else if (temp_in) begin
			s_next.temp_stat = 1'b1;
		end else if (temp_below_deassert) begin
			s_next.temp_stat = 1'b0;
		end
		if (!full_mode) begin
			s_next.lv_stat = 1'b0;
		end else if (lv_in) begin
			s_next.lv_stat = 1'b1;
		end else if (lv_above_deassert) begin
			s_next.lv_stat = 1'b0;
		end

		// -----------------------------------------------------------
		// wakeup timer
		// -----------------------------------------------------------
		wk_timeout = 1'b0;
		s_next.wk_pulse = 1'b0;
		if (!s_reg.wk.feat_en || s_reg.mode == RTC_SHUTDOWN) begin
			s_next.wk_cnt = s_reg.wk.rate;
		end else if (wake_tick) begin
			if (s_reg.wk_cnt == 16'h0000) begin
				s_next.wk_cnt = s_reg.wk.rate;
				s_next.wk_phase = !s_reg.wk_phase;
				s_next.wk_pulse = 1'b1;
				wk_timeout = 1'b1;
			end else begin
				s_next.wk_cnt = s_reg.wk_cnt - 16'h0001;
			end
		end

		// -----------------------------------------------------------
		// sticky flags; mode changes never clear them
		// -----------------------------------------------------------
		set_ev[IRQ_TEMP] = s_next.temp_stat != s_reg.temp_stat;
		set_ev[IRQ_LV] = s_next.lv_stat != s_reg.lv_stat;
		set_ev[IRQ_WK] = wk_timeout;
		clr_ev = 3'h0;
		if (wr && !bad) begin
			unique case (idx)
				IDX_TEMP_CTL: clr_ev[IRQ_TEMP] = wd[TC_FLAG];
				IDX_LV_CTL: clr_ev[IRQ_LV] = wd[LV_FLAG];
				IDX_WK_CTL: clr_ev[IRQ_WK] = wd[WK_FLAG];
				IDX_IRQ_STAT: clr_ev = wd[2:0];
				default: clr_ev = 3'h0;
			endcase
		end
		// set wins for the temperature and voltage flags
		s_next.flags[IRQ_TEMP] = set_ev[IRQ_TEMP] |
			(s_reg.flags[IRQ_TEMP] & ~clr_ev[IRQ_TEMP]);
		s_next.flags[IRQ_LV] = set_ev[IRQ_LV] |
			(s_reg.flags[IRQ_LV] & ~clr_ev[IRQ_LV]);
		// the wakeup flag lets the software clear win
		s_next.flags[IRQ_WK] = ~clr_ev[IRQ_WK] &
			(set_ev[IRQ_WK] | s_reg.flags[IRQ_WK]);

		// -----------------------------------------------------------
		// register writes
		// -----------------------------------------------------------
		if (wr && !bad) begin
			unique case (idx)
				IDX_TEMP_CTL: begin
					s_next.tc.voltage_source_select = wd[TC_VOLTAGE_SOURCE_SELECT];
					s_next.tc.voltage_access_enable = wd[TC_VAE];
					s_next.tc.en = wd[TC_EN];
					s_next.tc.ie = wd[TC_IE];
					if (s_reg.sys[SYS_TEST])
						s_next.tc.test = wd[TC_TEST_HI:TC_TEST_LO];
				end
				IDX_LV_CTL: s_next.lv_ie = wd[LV_IE];
				IDX_WK_CTL: begin
					if (!s_reg.wk.feat_en)
						s_next.wk.clk_sel = wd[WK_CLK];
					s_next.wk.ext_sel = wd[WK_ES];
					s_next.wk.ext_acc = wd[WK_EA];
					s_next.wk.feat_en = wd[WK_FE];
					s_next.wk.ie = wd[WK_IE];
				end
				IDX_WK_TRIM: s_next.wk.trim = wd & WK_TRIM_MASK;
				IDX_WK_RATE_HI: s_next.wk.rate[15:8] = wd;
				IDX_WK_RATE_LO: s_next.wk.rate[7:0] = wd;
				IDX_TEMP_TRIM: s_next.temp_trim = wd & TT_MASK;
				IDX_IRQ_MASK: s_next.mask = wd[2:0];
				IDX_SYS_CTL: s_next.sys = wd[2:0];
				default: ;
			endcase
		end

		// -----------------------------------------------------------
		// read mux; unlisted bits read zero
		// -----------------------------------------------------------
		unique case (idx)
			IDX_TEMP_CTL: rd = {s_reg.tc.test, s_reg.tc.voltage_source_select, s_reg.tc.voltage_access_enable,
				s_reg.tc.en, s_reg.temp_stat, s_reg.tc.ie,
				s_reg.flags[IRQ_TEMP]};
			IDX_LV_CTL: rd = {5'h00, s_reg.lv_stat, s_reg.lv_ie,
				s_reg.flags[IRQ_LV]};
			IDX_WK_CTL: rd = {s_reg.wk.clk_sel, 2'h0, s_reg.wk.ext_sel,
				s_reg.wk.ext_acc, s_reg.wk.feat_en, s_reg.wk.ie,
				s_reg.flags[IRQ_WK]};
			IDX_WK_TRIM: rd = s_reg.wk.trim;
			IDX_WK_RATE_HI: rd = s_reg.wk.rate[15:8];
			IDX_WK_RATE_LO: rd = s_reg.wk.rate[7:0];
			IDX_TEMP_TRIM: rd = s_reg.temp_trim;
			IDX_IRQ_STAT: rd = {5'h00, s_reg.flags};
			IDX_IRQ_MASK: rd = {5'h00, s_reg.mask};
			IDX_SYS_CTL: rd = {5'h00, s_reg.sys};
			default: rd = ZERO8;
		endcase

		// one wait state: answer in the cycle after the first access
		s_next.pready = acc;
		s_next.pslverr = acc && bad;
		if (acc && !pwrite && !bad)
			s_next.prdata = {24'h000000, rd};
		else if (acc)
			s_next.prdata = 32'h00000000;

		// -----------------------------------------------------------
		// outputs
		// -----------------------------------------------------------
		s_next.irq_temp = s_next.flags[IRQ_TEMP] && s_next.tc.ie;
		s_next.irq_lv = s_next.flags[IRQ_LV] && s_next.lv_ie;
		s_next.irq = |(s_next.flags & s_next.mask & IRQ_BITS);
		s_next.sense_on = s_next.tc.en && s_next.mode == RTC_FULL;
		s_next.adc_int = s_next.tc.voltage_access_enable;
		s_next.adc_bg = s_next.tc.voltage_access_enable && s_next.tc.voltage_source_select;
		if (s_next.sys[SYS_PINEN] && s_next.wk.ext_acc && s_next.wk.feat_en)
			s_next.wk_pin = s_next.wk.ext_sel ? s_next.wk_phase
				: s_next.wk_pulse;
		else
			s_next.wk_pin = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.tc.voltage_access_enable <= TC_RESET[TC_VAE];
			s_reg.adc_int <= TC_RESET[TC_VAE];
			s_reg.sys <= SYS_RESET;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign prdata = s_reg.prdata;
	assign temp_sense_on = s_reg.sense_on;
	assign adc_internal_sel = s_reg.adc_int;
	assign adc_bandgap_sel = s_reg.adc_bg;
	assign periodic_wakeup_output_pin = s_reg.wk_pin;
	assign temp_irq = s_reg.irq_temp;
	assign lv_irq = s_reg.irq_lv;
	assign irq = s_reg.irq;

endmodule
